// [core/ccc_handler.sv]
// configuration command interpreter of a dual-interface reader, with Avalon-MM slave
// assumes TAG_* and SPEED_* come from logic on CLK; CONTACT_PRESENT is an async pin
//
// Function
// RQ1 - detection-type read E0 00 00 20 Lc 00 answers E1, Le 01, stored byte
// RQ2 - detection bit 0 enables type A, bit 1 type B; bits 2-7 reserved
// RQ3 - sharing-mode write P2 2B Lc 01 answers Le 02, configured and active mode
// RQ4 - sharing-mode read P2 2B Lc 00 answers E1, Le 02, configured and active mode
// RQ5 - mode 00 lets contact and contactless interfaces run concurrently
// RQ6 - mode 01, default, stops polling and field while a contact card sits
// RQ7 - on each tag found try configured maximum speed, then step slower on refusal
// RQ8 - speed write P2 24 Lc 01 answers Le 02, maximum then current speed
// RQ9 - speed read P2 24 Lc 00 answers E1, Le 02, maximum then current speed
// RQ10 - speed codes 00..03 for 106..848 kbps; 00 default, no negotiation
// RQ11 - accepted speed is used without any further checking
// RQ12 - poll for tags continuously and send the answer-to-reset once found
// RQ13 - host connects with T=1, exchanges APDUs, then disconnects
// RQ14 - host keeps the command format of its first APDU after activation
// RQ15 - native tag commands, not wrapped, are accepted and forwarded to the tag
// RQ16 - host requests every further frame itself with AF; no device chaining
// RQ17 - native responses under two bytes get 90 00 appended, longer ones not
// RQ18 - detection write P2 20 Lc 01 echoes the byte; reset value 03
// RQ19 - config bytes load defaults at reset and read back exactly as written
//
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module ccc_handler (
  input  wire logic                  CLK,
  input  wire logic                  RESET,
  input  wire ccc_pkg::ccc_avs_req_t AVS_REQ,
  output logic [31:0]                AVS_READDATA,
  output logic                       AVS_WAITREQUEST,
  input  wire logic                  CONTACT_PRESENT,
  input  wire logic                  TAG_FOUND,
  input  wire logic                  SPEED_ACK,
  input  wire logic                  SPEED_NAK,
  input  wire logic                  TAG_RSP_DONE,
  input  wire logic [7:0]            TAG_RSP_LEN,
  output logic                       POLL_EN,
  output logic                       FIELD_ON,
  output logic                       DETECT_A,
  output logic                       DETECT_B,
  output logic                       ATR_SEND,
  output logic                       SPEED_REQ,
  output logic [7:0]                 SPEED_TRY,
  output logic                       TAG_CMD_VALID,
  output logic [7:0]                 TAG_CMD_BYTE,
  output logic                       HOST_RSP_VALID,
  output logic [7:0]                 HOST_RSP_LEN,
  output logic                       HOST_SW_APPEND
);
  import ccc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic        contact_s1;
    logic        contact_s2;
    logic        waitreq;
    logic [31:0] rdata;
    logic [31:0] cmd;
    logic [7:0]  det;
    logic [7:0]  mode_cfg;
    logic [7:0]  mode_cur;
    logic [7:0]  spd_max;
    logic [7:0]  spd_cur;
    logic [7:0]  spd_try;
    ccc_neg_t    neg;
    logic [31:0] rsp;
    logic        rsp_valid;
    logic        cmd_err;
    logic        fwd_valid;
    logic [7:0]  fwd_byte;
    logic        atr;
    logic        spd_req;
    logic        poll_en;
    logic        field_on;
    logic        host_valid;
    logic [7:0]  host_len;
    logic        host_sw;
  } ccc_state_t;

  ccc_state_t st_reg;
  ccc_state_t st_next;

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  be);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  // response word: class, length and up to two data bytes
  function automatic logic [31:0] rsp_word(input logic [7:0] le,
                                           input logic [7:0] b0,
                                           input logic [7:0] b1);
    return {b1, b0, le, CCC_CLA_RSP};
  endfunction : rsp_word

  //////////////////////////////////////////////////////////////////////////////
  // decoded command fields; the launch happens at the edge that ends the ARG write

  logic       access;
  logic       launch;
  logic [7:0] c_cla;
  logic [7:0] c_ins;
  logic [7:0] c_p1;
  logic [7:0] c_p2;
  logic [7:0] c_lc;
  logic [7:0] c_dat;
  logic       c_cfg;
  logic       c_rd;
  logic       c_wr;

  assign access = (AVS_REQ.read || AVS_REQ.write) && !st_reg.waitreq;
  assign launch = access && AVS_REQ.write && (AVS_REQ.address == CCC_OFS_ARG);
  assign c_cla  = st_reg.cmd[7:0];
  assign c_ins  = st_reg.cmd[15:8];
  assign c_p1   = st_reg.cmd[23:16];
  assign c_p2   = st_reg.cmd[31:24];
  assign c_lc   = AVS_REQ.writedata[7:0];
  assign c_dat  = AVS_REQ.writedata[15:8];
  assign c_cfg  = (c_cla == CCC_CLA_CMD) && (c_ins == CCC_INS_CFG) && (c_p1 == CCC_P1_CFG);
  assign c_rd   = c_cfg && (c_lc == CCC_LC_READ);
  assign c_wr   = c_cfg && (c_lc == CCC_LC_WRITE);

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    st_next = st_reg;
    st_next.contact_s1 = CONTACT_PRESENT;
    st_next.contact_s2 = st_reg.contact_s1;
    // one wait cycle per access keeps read data registered
    st_next.waitreq    = !((AVS_REQ.read || AVS_REQ.write) && st_reg.waitreq);
    st_next.fwd_valid  = 1'b0;
    st_next.atr        = 1'b0;
    st_next.spd_req    = 1'b0;
    st_next.host_valid = 1'b0;

    if (AVS_REQ.read && st_reg.waitreq) begin
      case (AVS_REQ.address)
        CCC_OFS_CMD:    st_next.rdata = st_reg.cmd;
        CCC_OFS_RSP:    st_next.rdata = st_reg.rsp;
        CCC_OFS_STATUS: st_next.rdata = {28'h0000000, (st_reg.neg != CCC_NEG_IDLE),
                                         st_reg.contact_s2, st_reg.cmd_err, st_reg.rsp_valid};
        default:        st_next.rdata = 32'h00000000;
      endcase
    end
    if (access && AVS_REQ.read && (AVS_REQ.address == CCC_OFS_RSP)) begin
      st_next.rsp_valid = 1'b0;
    end
    if (access && AVS_REQ.write && (AVS_REQ.address == CCC_OFS_CMD)) begin
      st_next.cmd = lane_merge(st_reg.cmd, AVS_REQ.writedata, AVS_REQ.byteenable);
    end

    // active mode follows the configured one only while no contact card sits,
    // so a mode change never pulls the field out from under a running session
    if (!st_reg.contact_s2) begin
      st_next.mode_cur = st_reg.mode_cfg;
    end

    if (launch) begin
      st_next.rsp_valid = 1'b1;
      st_next.cmd_err   = 1'b0;
      st_next.rsp       = rsp_word(CCC_LE_NONE, 8'h00, 8'h00);
      if (c_cla != CCC_CLA_CMD) begin
        // native tag command is passed through untouched
        st_next.fwd_valid = 1'b1; // RQ15
        st_next.fwd_byte  = c_cla;
        st_next.rsp_valid = 1'b0;
      end else if (c_wr && (c_p2 == CCC_P2_DETECT)) begin
        st_next.det = c_dat; // RQ18 RQ19
        st_next.rsp = rsp_word(CCC_LE_ONE, c_dat, 8'h00); // RQ18
      end else if (c_rd && (c_p2 == CCC_P2_DETECT)) begin
        st_next.rsp = rsp_word(CCC_LE_ONE, st_reg.det, 8'h00); // RQ1
      end else if (c_wr && (c_p2 == CCC_P2_SHARE)) begin
        st_next.mode_cfg = c_dat; // RQ19
        st_next.rsp = rsp_word(CCC_LE_TWO, c_dat, st_reg.mode_cur); // RQ3
      end else if (c_rd && (c_p2 == CCC_P2_SHARE)) begin
        st_next.rsp = rsp_word(CCC_LE_TWO, st_reg.mode_cfg, st_reg.mode_cur); // RQ4
      end else if (c_wr && (c_p2 == CCC_P2_SPEED)) begin
        st_next.spd_max = c_dat; // RQ19
        st_next.rsp = rsp_word(CCC_LE_TWO, c_dat, st_reg.spd_cur); // RQ8
      end else if (c_rd && (c_p2 == CCC_P2_SPEED)) begin
        st_next.rsp = rsp_word(CCC_LE_TWO, st_reg.spd_max, st_reg.spd_cur); // RQ9
      end else begin
        st_next.cmd_err = 1'b1;
      end
    end

    // exclusive mode stops polling and field while a contact card is present
    st_next.poll_en  = !((st_reg.mode_cur == CCC_MODE_EXCLUSIVE) && st_reg.contact_s2); // RQ5 RQ6
    st_next.field_on = st_next.poll_en; // RQ6

    case (st_reg.neg)
      CCC_NEG_IDLE: begin
        if (TAG_FOUND && st_reg.poll_en) begin
          st_next.atr = 1'b1; // RQ12
          if (st_reg.spd_max != CCC_SPEED_106) begin
            st_next.spd_try = st_reg.spd_max; // RQ7
            st_next.neg     = CCC_NEG_TRY;
          end else begin
            st_next.spd_cur = CCC_SPEED_106; // RQ10
          end
        end
      end
      CCC_NEG_TRY: begin
        st_next.spd_req = 1'b1; // RQ7
        st_next.neg     = CCC_NEG_WAIT;
      end
      CCC_NEG_WAIT: begin
        if (SPEED_ACK) begin
          // the accepted speed is kept as is; no link quality check follows
          st_next.spd_cur = st_reg.spd_try; // RQ11
          st_next.neg     = CCC_NEG_IDLE;
        end else if (SPEED_NAK) begin
          if (st_reg.spd_try > CCC_SPEED_212) begin
            st_next.spd_try = st_reg.spd_try - CCC_SPEED_STEP; // RQ7
            st_next.neg     = CCC_NEG_TRY;
          end else begin
            st_next.spd_cur = CCC_SPEED_106; // RQ7
            st_next.neg     = CCC_NEG_IDLE;
          end
        end
      end
      default: st_next.neg = CCC_NEG_IDLE;
    endcase

    // frames are never chained here; each continuation arrives as its own command
    if (TAG_RSP_DONE) begin
      st_next.host_valid = 1'b1;
      st_next.host_sw    = (TAG_RSP_LEN < CCC_NATIVE_MIN); // RQ17
      st_next.host_len   = (TAG_RSP_LEN < CCC_NATIVE_MIN) ?
                           8'(TAG_RSP_LEN + CCC_SW_LEN) : TAG_RSP_LEN; // RQ17
    end

    if (RESET) begin
      st_next          = '0;
      st_next.waitreq  = 1'b1;
      st_next.det      = CCC_RST_DETECT; // RQ18 RQ19
      st_next.mode_cfg = CCC_RST_MODE; // RQ6 RQ19
      st_next.mode_cur = CCC_RST_MODE;
      st_next.spd_max  = CCC_RST_SPEED; // RQ10 RQ19
      st_next.spd_cur  = CCC_RST_SPEED;
      st_next.neg      = CCC_NEG_IDLE;
    end
  end

  always_ff @(posedge CLK) begin
    st_reg <= st_next;
  end

  //////////////////////////////////////////////////////////////////////////////

  assign AVS_READDATA    = st_reg.rdata;
  assign AVS_WAITREQUEST = st_reg.waitreq;
  assign POLL_EN         = st_reg.poll_en;
  assign FIELD_ON        = st_reg.field_on;
  assign DETECT_A        = st_reg.det[CCC_DET_TYPE_A]; // RQ2
  assign DETECT_B        = st_reg.det[CCC_DET_TYPE_B]; // RQ2
  assign ATR_SEND        = st_reg.atr;
  assign SPEED_REQ       = st_reg.spd_req;
  assign SPEED_TRY       = st_reg.spd_try;
  assign TAG_CMD_VALID   = st_reg.fwd_valid;
  assign TAG_CMD_BYTE    = st_reg.fwd_byte;
  assign HOST_RSP_VALID  = st_reg.host_valid;
  assign HOST_RSP_LEN    = st_reg.host_len;
  assign HOST_SW_APPEND  = st_reg.host_sw;

  //////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  a_det_read_rsp: assert property ( // RQ1
    launch && c_rd && (c_p2 == CCC_P2_DETECT) |=>
      st_reg.rsp == {8'h00, $past(st_reg.det), CCC_LE_ONE, CCC_CLA_RSP})
    else $error("detection read response wrong");

  a_det_bits_out: assert property ( // RQ2
    launch && c_wr && (c_p2 == CCC_P2_DETECT) |=>
      DETECT_A == $past(c_dat[0]) && DETECT_B == $past(c_dat[1]) [*2])
    else $error("detection bits not driven from stored byte");

  a_mode_write_rsp: assert property ( // RQ3
    launch && c_wr && (c_p2 == CCC_P2_SHARE) |=>
      st_reg.rsp[15:0] == {CCC_LE_TWO, CCC_CLA_RSP} && st_reg.rsp[23:16] == $past(c_dat)
      && st_reg.mode_cfg == $past(c_dat))
    else $error("sharing write not stored or echoed");

  a_mode_read_rsp: assert property ( // RQ4
    launch && c_rd && (c_p2 == CCC_P2_SHARE) |=>
      st_reg.rsp == {$past(st_reg.mode_cur), $past(st_reg.mode_cfg), CCC_LE_TWO, CCC_CLA_RSP})
    else $error("sharing read response wrong");

  a_share_field_on: assert property ( // RQ5
    (st_reg.mode_cur == CCC_MODE_SHARE) |=> FIELD_ON && POLL_EN)
    else $error("share mode blocked contactless side");

  a_excl_field_off: assert property ( // RQ6
    (CONTACT_PRESENT && st_reg.mode_cur == CCC_MODE_EXCLUSIVE) [*3] |=> !FIELD_ON && !POLL_EN)
    else $error("exclusive mode kept field on with contact card");

  a_speed_step_down: assert property ( // RQ7
    st_reg.neg == CCC_NEG_WAIT && !SPEED_ACK && SPEED_NAK && st_reg.spd_try > CCC_SPEED_212
      |=> ##1 SPEED_REQ && SPEED_TRY == $past(st_reg.spd_try, 2) - CCC_SPEED_STEP)
    else $error("refused speed not retried one step slower");

  a_speed_rd_rsp: assert property ( // RQ9
    launch && c_rd && (c_p2 == CCC_P2_SPEED) |=>
      st_reg.rsp == {$past(st_reg.spd_cur), $past(st_reg.spd_max), CCC_LE_TWO, CCC_CLA_RSP})
    else $error("speed read response wrong");

  a_zero_no_neg: assert property ( // RQ10
    st_reg.neg == CCC_NEG_IDLE && TAG_FOUND && POLL_EN && st_reg.spd_max == CCC_SPEED_106
      |=> st_reg.neg == CCC_NEG_IDLE ##1 !SPEED_REQ)
    else $error("negotiation started at lowest speed setting");

  a_speed_accept: assert property ( // RQ11
    st_reg.neg == CCC_NEG_WAIT && SPEED_ACK |=>
      st_reg.spd_cur == $past(st_reg.spd_try) && st_reg.neg == CCC_NEG_IDLE)
    else $error("accepted speed not taken as current");

  a_atr_on_found: assert property ( // RQ12
    TAG_FOUND && POLL_EN && st_reg.neg == CCC_NEG_IDLE |=> ATR_SEND ##1 !ATR_SEND)
    else $error("answer-to-reset not sent once");

  a_native_fwd: assert property ( // RQ15
    launch && c_cla != CCC_CLA_CMD |=> TAG_CMD_VALID && TAG_CMD_BYTE == $past(c_cla))
    else $error("native command not forwarded");

  a_sw_append_len: assert property ( // RQ17
    TAG_RSP_DONE |=> HOST_RSP_VALID && HOST_SW_APPEND == ($past(TAG_RSP_LEN) < CCC_NATIVE_MIN)
      && HOST_RSP_LEN >= CCC_NATIVE_MIN)
    else $error("status word handling wrong");

  a_reset_values: assert property ( // RQ19
    $past(RESET) |-> st_reg.det == CCC_RST_DETECT && st_reg.mode_cfg == CCC_RST_MODE
      && st_reg.spd_max == CCC_RST_SPEED)
    else $error("configuration defaults missing after reset");

endmodule : ccc_handler

`default_nettype wire

// [core/ccc_pkg.sv]
// constants, codes and carrier types of the contactless configuration command handler
// assumes a single 100 MHz clock domain and a word-aligned Avalon-MM slave port
package ccc_pkg;

  // register byte offsets
  localparam logic [3:0] CCC_OFS_CMD    = 4'h0;
  localparam logic [3:0] CCC_OFS_ARG    = 4'h4;
  localparam logic [3:0] CCC_OFS_RSP    = 4'h8;
  localparam logic [3:0] CCC_OFS_STATUS = 4'hc;

  // command and response framing bytes
  localparam logic [7:0] CCC_CLA_CMD   = 8'he0;
  localparam logic [7:0] CCC_CLA_RSP   = 8'he1;
  localparam logic [7:0] CCC_INS_CFG   = 8'h00;
  localparam logic [7:0] CCC_P1_CFG    = 8'h00;
  localparam logic [7:0] CCC_P2_DETECT = 8'h20;
  localparam logic [7:0] CCC_P2_SPEED  = 8'h24;
  localparam logic [7:0] CCC_P2_SHARE  = 8'h2b;
  localparam logic [7:0] CCC_LC_READ   = 8'h00;
  localparam logic [7:0] CCC_LC_WRITE  = 8'h01;
  localparam logic [7:0] CCC_LE_NONE   = 8'h00;
  localparam logic [7:0] CCC_LE_ONE    = 8'h01;
  localparam logic [7:0] CCC_LE_TWO    = 8'h02;

  // sharing modes and link speed codes
  localparam logic [7:0] CCC_MODE_SHARE     = 8'h00;
  localparam logic [7:0] CCC_MODE_EXCLUSIVE = 8'h01;
  localparam logic [7:0] CCC_SPEED_106      = 8'h00;
  localparam logic [7:0] CCC_SPEED_212      = 8'h01;
  localparam logic [7:0] CCC_SPEED_424      = 8'h02;
  localparam logic [7:0] CCC_SPEED_848      = 8'h03;
  localparam logic [7:0] CCC_SPEED_STEP     = 8'h01;

  // values after reset
  localparam logic [7:0] CCC_RST_DETECT = 8'h03;
  localparam logic [7:0] CCC_RST_MODE   = CCC_MODE_EXCLUSIVE;
  localparam logic [7:0] CCC_RST_SPEED  = CCC_SPEED_106;

  // native-format response: status word and shortest length without it
  localparam logic [7:0] CCC_SW_LEN     = 8'h02;
  localparam logic [7:0] CCC_NATIVE_MIN = 8'h02;

  // detection byte field positions
  localparam int CCC_DET_TYPE_A = 0;
  localparam int CCC_DET_TYPE_B = 1;

  typedef enum logic [2:0] {
    CCC_NEG_IDLE = 3'b001,
    CCC_NEG_TRY  = 3'b010,
    CCC_NEG_WAIT = 3'b100
  } ccc_neg_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } ccc_avs_req_t;

endpackage : ccc_pkg

// [verif/ccc_tag_model.sv]
// behavioural proximity card on the tag side of the command handler
// assumes one clock shared with the handler and its synchronous reset
`timescale 1ns/1ps
`default_nettype none

module ccc_tag_model #(
  parameter logic [7:0] SPEED_LIMIT = 8'h01
) (
  input  wire logic       CLK,
  input  wire logic       RESET,
  input  wire logic       SPEED_REQ,
  input  wire logic [7:0] SPEED_TRY,
  input  wire logic       TAG_CMD_VALID,
  input  wire logic [7:0] TAG_CMD_BYTE,
  output logic            SPEED_ACK,
  output logic            SPEED_NAK,
  output logic            TAG_RSP_DONE,
  output logic [7:0]      TAG_RSP_LEN
);
  int         spd_cnt;
  int         rsp_cnt;
  logic [7:0] try_hold;
  logic [7:0] len_hold;

  ////////////////////////////////////////////////////////////////////////////////
  // faster speeds answer later, so both prompt and slow replies occur
  always @(posedge CLK) begin
    SPEED_ACK    <= 1'b0;
    SPEED_NAK    <= 1'b0;
    TAG_RSP_DONE <= 1'b0;
    // length only means something with the done pulse
    TAG_RSP_LEN  <= ~TAG_RSP_LEN;
    if (RESET) begin
      spd_cnt     <= 0;
      rsp_cnt     <= 0;
      TAG_RSP_LEN <= 8'h5a;
    end else begin
      if (SPEED_REQ) begin
        spd_cnt  <= 1 + int'(SPEED_TRY);
        try_hold <= SPEED_TRY;
      end else if (spd_cnt == 1) begin
        SPEED_ACK <= (try_hold <= SPEED_LIMIT);
        SPEED_NAK <= (try_hold > SPEED_LIMIT);
        spd_cnt   <= 0;
      end else if (spd_cnt > 1) begin
        spd_cnt <= spd_cnt - 1;
      end
      if (TAG_CMD_VALID) begin
        rsp_cnt  <= 2;
        // the command byte doubles as the reply length, so a continuation byte gets a long reply
        len_hold <= TAG_CMD_BYTE;
      end else if (rsp_cnt == 1) begin
        TAG_RSP_DONE <= 1'b1;
        TAG_RSP_LEN  <= len_hold;
        rsp_cnt      <= 0;
      end else if (rsp_cnt > 1) begin
        rsp_cnt <= rsp_cnt - 1;
      end
    end
  end
endmodule : ccc_tag_model
`default_nettype wire

// [verif/testbench.sv]
// self-checking bench of the configuration command handler
// assumes ccc_pkg is compiled first and the tag model sits on the tag ports
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import ccc_pkg::*;

  typedef struct packed {
    logic [7:0]  p2;
    logic [7:0]  lc;
    logic [7:0]  dat;
    logic [31:0] exp;
    logic [31:0] msk;
  } ccc_row_t;

  logic CLK, RESET, wait_req, contact, tag_found, s_ack, s_nak, r_done, poll_en, field_on;
  logic det_a, det_b, atr, s_req, c_valid, h_valid, sw_app;
  logic [7:0]   r_len, s_try, c_byte, h_len;
  logic [31:0]  rdata, r;
  ccc_avs_req_t req;
  int           error_cnt = 0;
  int           total_checks = 0;
  int           cyc = 0, atr_cnt = 0, req_cnt = 0, ack_cnt = 0, host_cnt = 0, n;
  logic [23:0]  tries = '0;
  logic [7:0]   fwd_byte;
  logic [7:0]   lens [5] = '{8'h00, 8'h01, 8'h02, 8'h0a, 8'haf};
  int           again [3] = '{0, 3, 6};
  ccc_row_t     rows [10] = '{
    '{8'h20, 8'h00, 8'h00, 32'h0003_01e1, 32'h00ff_ffff},
    '{8'h20, 8'h01, 8'hfd, 32'h00fd_01e1, 32'h00ff_ffff},
    '{8'h20, 8'h00, 8'h00, 32'h00fd_01e1, 32'h00ff_ffff},
    '{8'h2b, 8'h00, 8'h00, 32'h0101_02e1, 32'hffff_ffff},
    '{8'h2b, 8'h01, 8'h00, 32'h0100_02e1, 32'hffff_ffff},
    '{8'h2b, 8'h00, 8'h00, 32'h0000_02e1, 32'hffff_ffff},
    '{8'h24, 8'h00, 8'h00, 32'h0000_02e1, 32'hffff_ffff},
    '{8'h24, 8'h01, 8'h03, 32'h0003_02e1, 32'hffff_ffff},
    '{8'h24, 8'h00, 8'h00, 32'h0003_02e1, 32'hffff_ffff},
    '{8'h55, 8'h00, 8'h00, 32'h0000_00e1, 32'h0000_ffff}};

  ccc_handler dut (.CLK(CLK), .RESET(RESET), .AVS_REQ(req), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wait_req), .CONTACT_PRESENT(contact), .TAG_FOUND(tag_found),
    .SPEED_ACK(s_ack), .SPEED_NAK(s_nak), .TAG_RSP_DONE(r_done), .TAG_RSP_LEN(r_len),
    .POLL_EN(poll_en), .FIELD_ON(field_on), .DETECT_A(det_a), .DETECT_B(det_b),
    .ATR_SEND(atr), .SPEED_REQ(s_req), .SPEED_TRY(s_try), .TAG_CMD_VALID(c_valid),
    .TAG_CMD_BYTE(c_byte), .HOST_RSP_VALID(h_valid), .HOST_RSP_LEN(h_len),
    .HOST_SW_APPEND(sw_app));

  ccc_tag_model #(.SPEED_LIMIT(8'h01)) card (.CLK(CLK), .RESET(RESET), .SPEED_REQ(s_req),
    .SPEED_TRY(s_try), .TAG_CMD_VALID(c_valid), .TAG_CMD_BYTE(c_byte), .SPEED_ACK(s_ack),
    .SPEED_NAK(s_nak), .TAG_RSP_DONE(r_done), .TAG_RSP_LEN(r_len));

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (atr === 1'b1) atr_cnt <= atr_cnt + 1;
    if (s_ack === 1'b1) ack_cnt <= ack_cnt + 1;
    if (h_valid === 1'b1) host_cnt <= host_cnt + 1;
    if (c_valid === 1'b1) fwd_byte <= c_byte;
    if (s_req === 1'b1) begin
      req_cnt <= req_cnt + 1;
      tries   <= {tries[15:0], s_try};
    end
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      end_sim();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // request held until waitrequest is sampled low, then released at that edge
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge CLK);
    req <= '{read: ~wr, write: wr, address: adr, byteenable: 4'hf, writedata: wd};
    do @(posedge CLK); while (wait_req !== 1'b0);
    rd = rdata;
    req.read  <= 1'b0;
    req.write <= 1'b0;
  endtask : bus

  task automatic cmd(input logic [7:0] cla, p2, lc, dat, output logic [31:0] rsp);
    logic [31:0] d;
    bus(1'b1, CCC_OFS_CMD, {p2, CCC_P1_CFG, CCC_INS_CFG, cla}, d);
    bus(1'b1, CCC_OFS_ARG, {16'h0, dat, lc}, d);
    bus(1'b0, CCC_OFS_RSP, 32'h0, rsp);
  endtask : cmd

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    RESET = 1'b1;
    req = '0;
    contact = 1'b0;
    tag_found = 1'b0;
    repeat (6) @(posedge CLK);
    check("wait_in_reset", 32'(wait_req), 32'h1);
    check("det_a_reset", 32'(det_a & det_b), 32'h1);
    RESET <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      cmd(CCC_CLA_CMD, rows[i].p2, rows[i].lc, rows[i].dat, r);
      check("rsp", r & rows[i].msk, rows[i].exp);
    end
    check("det_a", 32'(det_a), 32'h1);
    check("det_b", 32'(det_b), 32'h0);
    $display("test table done");
    @(posedge CLK) tag_found <= 1'b1;
    @(posedge CLK) tag_found <= 1'b0;
    for (int i = 0; i < 200 && ack_cnt == 0; i++) @(posedge CLK);
    check("tries", 32'(tries), 32'h0003_0201);
    check("atr", 32'(atr_cnt), 32'h1);
    cmd(CCC_CLA_CMD, CCC_P2_SPEED, CCC_LC_READ, 8'h00, r);
    check("speed", r, 32'h0103_02e1);
    cmd(CCC_CLA_CMD, CCC_P2_SPEED, CCC_LC_WRITE, CCC_SPEED_106, r);
    check("speed_wr", r, 32'h0100_02e1);
    @(posedge CLK) tag_found <= 1'b1;
    @(posedge CLK) tag_found <= 1'b0;
    repeat (20) @(posedge CLK);
    check("no_try", 32'(req_cnt), 32'h3);
    check("atr2", 32'(atr_cnt), 32'h2);
    cmd(CCC_CLA_CMD, CCC_P2_SPEED, CCC_LC_READ, 8'h00, r);
    check("speed0", r, 32'h0000_02e1);
    $display("test speed done");
    @(posedge CLK) contact <= 1'b1;
    repeat (4) @(posedge CLK);
    check("poll_share", 32'(poll_en & field_on), 32'h1);
    contact <= 1'b0;
    repeat (4) @(posedge CLK);
    cmd(CCC_CLA_CMD, CCC_P2_SHARE, CCC_LC_WRITE, CCC_MODE_EXCLUSIVE, r);
    check("share_wr", r, 32'h0001_02e1);
    @(posedge CLK) contact <= 1'b1;
    repeat (4) @(posedge CLK);
    check("poll_excl", 32'(poll_en | field_on), 32'h0);
    contact <= 1'b0;
    repeat (4) @(posedge CLK);
    check("poll_back", 32'(poll_en), 32'h1);
    $display("test mode done");
    foreach (lens[k]) begin
      n = host_cnt;
      cmd(lens[k], 8'h00, 8'h00, 8'h00, r);
      for (int i = 0; i < 50 && host_cnt == n; i++) @(posedge CLK);
      check("fwd", 32'(fwd_byte), 32'(lens[k]));
      check("len", 32'(h_len), lens[k] < 2 ? 32'(lens[k]) + 2 : 32'(lens[k]));
      check("sw", 32'(sw_app), 32'(lens[k] < 8'h02));
    end
    $display("test native done");
    @(posedge CLK) RESET <= 1'b1;
    repeat (6) @(posedge CLK);
    RESET <= 1'b0;
    foreach (again[k]) begin
      cmd(CCC_CLA_CMD, rows[again[k]].p2, 8'h00, 8'h00, r);
      check("rsp_rst", r & rows[again[k]].msk, rows[again[k]].exp);
    end
    $display("test reset done");
    end_sim();
  end
endmodule : testbench
`default_nettype wire
